// *** rtl/tcc_consts.svh ***
/*
 * Byte offsets, field positions, reset values and timing counts of the timer block.
 * Assumes an 8-bit register bus with one-cycle strobes.
 */
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// ----------------------------------------
// device byte offsets
// ----------------------------------------
`define TCC_A_CNT_LO 4'h0
`define TCC_A_CNT_HI 4'h1
`define TCC_A_CAP_LO 4'h2
`define TCC_A_CAP_HI 4'h3
`define TCC_A_CTRL_A 4'h4
`define TCC_A_CTRL_B 4'h5
`define TCC_A_FLAGS 4'h6
`define TCC_A_MASK 4'h7
`define TCC_A_CMP_CS 4'h8
`define TCC_A_PIN_CTL 4'h9

// ----------------------------------------
// field positions
// ----------------------------------------
`define TCC_B_FILT_EN 7
`define TCC_B_EDGE_RISE 6
`define TCC_F_OVF 0
`define TCC_F_CAP 5
`define TCC_C_CAP_SEL 2
`define TCC_C_CMP_OUT 5
`define TCC_P_DRIVE 0
`define TCC_P_OVERRIDE 1

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define TCC_RST_BYTE 8'h00
`define TCC_RST_WORD 16'h0000
`define TCC_MAX 16'hFFFF
`define TCC_TOP_8 16'h00FF
`define TCC_TOP_9 16'h01FF
`define TCC_TOP_10 16'h03FF
`define TCC_FILT_LEN 4

// ----------------------------------------
// host command register offsets and bits
// ----------------------------------------
`define TCC_H_ADDR 3'h0
`define TCC_H_DLO 3'h1
`define TCC_H_DHI 3'h2
`define TCC_H_CMD 3'h3
`define TCC_H_STAT 3'h4
`define TCC_H_RLO 3'h5
`define TCC_H_RHI 3'h6
`define TCC_H_ACK 3'h7
`define TCC_CMD_W16 0
`define TCC_CMD_R16 1
`define TCC_CMD_W8 2
`define TCC_CMD_R8 3
`define TCC_CMD_W16_LO 4

`endif

// *** rtl/tcc_pkg.sv ***
/*
 * Types shared by both ends of the timer block.
 * Assumes tcc_consts.svh for all numbers.
 */
package tcc_pkg;

   typedef enum logic [2:0] {
      H_IDLE,
      H_WR_HI,
      H_WR_LO,
      H_RD_LO,
      H_RD_HI,
      H_RD_END
   } tcc_hstate_t;

   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] icr;
      logic [7:0] temp;
      logic [7:0] ctrl_a;
      logic [7:0] ctrl_b;
      logic [7:0] flags;
      logic [7:0] mask;
      logic cap_sel;
      logic [1:0] pin_ctl;
      logic [9:0] presc;
      logic pin_s1;
      logic pin_s2;
      logic cmp_s1;
      logic cmp_s2;
      logic ext_s1;
      logic ext_s2;
      logic ext_prev;
      logic [3:0] hist;
      logic filt;
      logic filt_prev;
      logic down;
      logic [7:0] rdata;
   } tcc_dev_t;

   typedef struct packed {
      tcc_hstate_t st;
      logic [3:0] addr;
      logic [7:0] dlo;
      logic [7:0] dhi;
      logic [7:0] rlo;
      logic [7:0] rhi;
      logic [7:0] rdata;
      logic [3:0] bus_addr;
      logic [7:0] bus_wdata;
      logic bus_wr;
      logic bus_rd;
      logic ack_ovf;
      logic ack_cap;
      logic rd_pend;
      logic [3:0] rd_addr;
   } tcc_host_t;

endpackage

// *** rtl/tcc_if.sv ***
/*
 * Register bus between the host controller and the timer device.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps

interface tcc_if;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic irq;
   logic ack_ovf;
   logic ack_cap;

   modport dev (input addr, input wdata, input wr, input rd, output rdata, output irq,
                input ack_ovf, input ack_cap);
   modport host (output addr, output wdata, output wr, output rd, input rdata, input irq,
                 output ack_ovf, output ack_cap);
endinterface

// *** rtl/tcc_device.sv ***
/*
 * Timer device end: 16-bit counter, shared high-byte latch, input capture with filter.
 * Assumes one 20 MHz clock and a host that honours byte order on 16-bit accesses.
 */
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "tcc_consts.svh"

module tcc_device (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RSTN,
   // register bus
   tcc_if.dev BUS,
   // capture and tick sources
   input wire logic CAPTURE_PIN,
   input wire logic COMPARATOR_OUTPUT,
   input wire logic EXT_TICK_PIN,
   // counter state
   output logic TOP_HIT,
   output logic BOTTOM_HIT,
   output logic COUNT_DOWN
);

   tcc_pkg::tcc_dev_t s_q;
   tcc_pkg::tcc_dev_t s_d;
   logic [3:0] mode;
   logic [2:0] tsel;
   logic [15:0] top;
   logic icr_top;
   logic dual;
   logic fast;
   logic tick;
   logic ext_edge;
   logic src;
   logic edge_hit;
   logic cap_evt;
   logic ovf_evt;
   logic cnt_wr;

   // ----------------------------------------
   // mode decode
   // ----------------------------------------
   // split mode field
   assign mode = {s_q.ctrl_b[4:3], s_q.ctrl_a[1:0]};
   assign tsel = s_q.ctrl_b[2:0];
   assign icr_top = (mode == 4'h8) || (mode == 4'hA) || (mode == 4'hC) || (mode == 4'hE);
   assign dual = (mode == 4'h1) || (mode == 4'h2) || (mode == 4'h3) || (mode == 4'h8) ||
                 (mode == 4'h9) || (mode == 4'hA) || (mode == 4'hB);
   assign fast = (mode == 4'h5) || (mode == 4'h6) || (mode == 4'h7) || (mode == 4'hE) ||
                 (mode == 4'hF);

   always_comb begin
      case (mode)
         4'h1, 4'h5: top = `TCC_TOP_8;
         4'h2, 4'h6: top = `TCC_TOP_9;
         4'h3, 4'h7: top = `TCC_TOP_10;
         4'h8, 4'hA, 4'hC, 4'hE: top = s_q.icr;
         // no compare registers here, so their top modes run to max
         default: top = `TCC_MAX;
      endcase
   end

   // ----------------------------------------
   // tick select
   // ----------------------------------------
   assign ext_edge = (tsel[0]) ? (s_q.ext_s2 & ~s_q.ext_prev) : (~s_q.ext_s2 & s_q.ext_prev);

   always_comb begin
      case (tsel)
         3'h1: tick = 1'b1;
         3'h2: tick = (s_q.presc[2:0] == 3'h7);
         3'h3: tick = (s_q.presc[5:0] == 6'h3F);
         3'h4: tick = (s_q.presc[7:0] == 8'hFF);
         3'h5: tick = (s_q.presc == 10'h3FF);
         3'h6, 3'h7: tick = ext_edge;
         default: tick = 1'b0;
      endcase
   end

   // ----------------------------------------
   // capture source, filter and edge
   // ----------------------------------------
   // comparator or pin, after sync
   // port drive stands in for either source, pin or comparator
   assign src = s_q.pin_ctl[`TCC_P_OVERRIDE] ? s_q.pin_ctl[`TCC_P_DRIVE] :
                (s_q.cap_sel ? s_q.cmp_s2 : s_q.pin_s2);
   assign edge_hit = s_q.ctrl_b[`TCC_B_EDGE_RISE] ? (s_q.filt & ~s_q.filt_prev) :
                     (~s_q.filt & s_q.filt_prev);
   assign cap_evt = edge_hit & ~icr_top;
   assign cnt_wr = BUS.wr && (BUS.addr == `TCC_A_CNT_LO);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      ovf_evt = 1'b0;
      s_d.presc = s_q.presc + 10'h001;
      s_d.pin_s1 = CAPTURE_PIN;
      s_d.pin_s2 = s_q.pin_s1;
      s_d.cmp_s1 = COMPARATOR_OUTPUT;
      s_d.cmp_s2 = s_q.cmp_s1;
      s_d.ext_s1 = EXT_TICK_PIN;
      s_d.ext_s2 = s_q.ext_s1;
      s_d.ext_prev = s_q.ext_s2;

      s_d.hist = {s_q.hist[2:0], src};
      if (!s_q.ctrl_b[`TCC_B_FILT_EN]) begin
         s_d.filt = src;
      end else if (s_q.hist == 4'hF) begin
         s_d.filt = 1'b1;
      end else if (s_q.hist == 4'h0) begin
         s_d.filt = 1'b0;
      end
      s_d.filt_prev = s_q.filt;

      if (tick) begin
         if (dual) begin
            if (!s_q.down) begin
               if (s_q.cnt >= top) begin
                  s_d.down = 1'b1;
                  s_d.cnt = s_q.cnt - 16'h0001;
               end else begin
                  s_d.cnt = s_q.cnt + 16'h0001;
               end
            end else if (s_q.cnt == `TCC_RST_WORD) begin
               s_d.down = 1'b0;
               s_d.cnt = s_q.cnt + 16'h0001;
            end else begin
               s_d.cnt = s_q.cnt - 16'h0001;
            end
         end else begin
            s_d.down = 1'b0;
            s_d.cnt = (s_q.cnt == top) ? `TCC_RST_WORD : s_q.cnt + 16'h0001;
         end
         if (dual) begin
            ovf_evt = (s_q.cnt == `TCC_RST_WORD);
         end else if (fast) begin
            ovf_evt = (s_q.cnt == top);
         end else begin
            ovf_evt = (s_q.cnt == `TCC_MAX);
         end
      end

      if (cap_evt) begin
         s_d.icr = s_q.cnt;
      end

      // register writes
      if (BUS.wr) begin
         case (BUS.addr)
            `TCC_A_CNT_HI, `TCC_A_CAP_HI: s_d.temp = BUS.wdata;
            // latch plus low byte at once
            `TCC_A_CNT_LO: s_d.cnt = {s_q.temp, BUS.wdata};
            `TCC_A_CAP_LO: begin
               if (icr_top) begin
                  s_d.icr = {s_q.temp, BUS.wdata};
               end
            end
            `TCC_A_CTRL_A: s_d.ctrl_a = {6'h00, BUS.wdata[1:0]};
            `TCC_A_CTRL_B: s_d.ctrl_b = {BUS.wdata[7:6], 1'b0, BUS.wdata[4:0]};
            `TCC_A_FLAGS: s_d.flags = s_q.flags & ~(BUS.wdata & 8'h21);
            `TCC_A_MASK: s_d.mask = BUS.wdata & 8'h21;
            `TCC_A_CMP_CS: s_d.cap_sel = BUS.wdata[`TCC_C_CAP_SEL];
            `TCC_A_PIN_CTL: s_d.pin_ctl = BUS.wdata[1:0];
            default: s_d.temp = s_q.temp;
         endcase
      end

      if (BUS.ack_cap) begin
         s_d.flags[`TCC_F_CAP] = 1'b0;
      end
      if (BUS.ack_ovf) begin
         s_d.flags[`TCC_F_OVF] = 1'b0;
      end
      // flag with capture, set wins over clear
      if (cap_evt) begin
         s_d.flags[`TCC_F_CAP] = 1'b1;
      end
      if (ovf_evt && !cnt_wr) begin
         s_d.flags[`TCC_F_OVF] = 1'b1;
      end

      // register reads, data one cycle later
      s_d.rdata = `TCC_RST_BYTE;
      if (BUS.rd) begin
         case (BUS.addr)
            `TCC_A_CNT_LO: begin
               s_d.rdata = s_q.cnt[7:0];
               s_d.temp = s_q.cnt[15:8];
            end
            `TCC_A_CAP_LO: begin
               s_d.rdata = s_q.icr[7:0];
               s_d.temp = s_q.icr[15:8];
            end
            `TCC_A_CNT_HI, `TCC_A_CAP_HI: s_d.rdata = s_q.temp;
            `TCC_A_CTRL_A: s_d.rdata = s_q.ctrl_a;
            `TCC_A_CTRL_B: s_d.rdata = s_q.ctrl_b;
            `TCC_A_FLAGS: s_d.rdata = s_q.flags;
            `TCC_A_MASK: s_d.rdata = s_q.mask;
            `TCC_A_CMP_CS: s_d.rdata = {2'h0, s_q.cmp_s2, 2'h0, s_q.cap_sel, 2'h0};
            `TCC_A_PIN_CTL: s_d.rdata = {6'h00, s_q.pin_ctl};
            default: s_d.rdata = `TCC_RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // masked flags request interrupt
   assign BUS.irq = |(s_q.flags & s_q.mask);
   assign BUS.rdata = s_q.rdata;
   assign TOP_HIT = (s_q.cnt == top);
   assign BOTTOM_HIT = (s_q.cnt == `TCC_RST_WORD);
   assign COUNT_DOWN = s_q.down;

endmodule // tcc_device

// *** rtl/tcc_host.sv ***
/*
 * Host end: turns commands from its own registers into ordered byte accesses.
 * Assumes a device that answers reads one cycle after the strobe.
 */
`timescale 1ns/1ps
`include "tcc_consts.svh"

module tcc_host (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RSTN,
   // command port
   input wire logic [2:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   output logic IRQ,
   // device bus
   tcc_if.host BUS
);

   tcc_pkg::tcc_host_t s_q;
   tcc_pkg::tcc_host_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.bus_wr = 1'b0;
      s_d.bus_rd = 1'b0;
      s_d.ack_ovf = 1'b0;
      s_d.ack_cap = 1'b0;
      s_d.rdata = `TCC_RST_BYTE;
      // device answers one cycle after the strobe, so take the byte then
      s_d.rd_pend = s_q.bus_rd;
      s_d.rd_addr = s_q.bus_addr;
      if (s_q.rd_pend) begin
         // 8-bit reads land in the low result
         if (s_q.rd_addr == s_q.addr) begin
            s_d.rlo = BUS.rdata;
         end else begin
            s_d.rhi = BUS.rdata;
         end
      end
      case (s_q.st)
         tcc_pkg::H_IDLE: begin
            if (WR && ADDR == `TCC_H_CMD) begin
               if (WDATA[`TCC_CMD_W16]) begin
                  s_d.st = tcc_pkg::H_WR_HI;
               end else if (WDATA[`TCC_CMD_W16_LO]) begin
                  // latch reused, only low byte sent
                  s_d.st = tcc_pkg::H_WR_LO;
               end else if (WDATA[`TCC_CMD_R16]) begin
                  s_d.st = tcc_pkg::H_RD_LO;
               end else if (WDATA[`TCC_CMD_W8]) begin
                  s_d.bus_wr = 1'b1;
                  s_d.bus_addr = s_q.addr;
                  s_d.bus_wdata = s_q.dlo;
               end else if (WDATA[`TCC_CMD_R8]) begin
                  s_d.bus_rd = 1'b1;
                  s_d.bus_addr = s_q.addr;
                  s_d.st = tcc_pkg::H_RD_END;
               end
            end
         end
         tcc_pkg::H_WR_HI: begin
            s_d.bus_wr = 1'b1;
            s_d.bus_addr = s_q.addr + 4'h1;
            s_d.bus_wdata = s_q.dhi;
            s_d.st = tcc_pkg::H_WR_LO;
         end
         tcc_pkg::H_WR_LO: begin
            s_d.bus_wr = 1'b1;
            s_d.bus_addr = s_q.addr;
            s_d.bus_wdata = s_q.dlo;
            s_d.st = tcc_pkg::H_IDLE;
         end
         tcc_pkg::H_RD_LO: begin
            s_d.bus_rd = 1'b1;
            s_d.bus_addr = s_q.addr;
            s_d.st = tcc_pkg::H_RD_HI;
         end
         tcc_pkg::H_RD_HI: begin
            s_d.bus_rd = 1'b1;
            s_d.bus_addr = s_q.addr + 4'h1;
            s_d.st = tcc_pkg::H_RD_END;
         end
         tcc_pkg::H_RD_END: begin
            s_d.st = tcc_pkg::H_IDLE;
         end
         default: s_d.st = tcc_pkg::H_IDLE;
      endcase
      if (WR) begin
         case (ADDR)
            `TCC_H_ADDR: s_d.addr = WDATA[3:0];
            `TCC_H_DLO: s_d.dlo = WDATA;
            `TCC_H_DHI: s_d.dhi = WDATA;
            `TCC_H_ACK: begin
               s_d.ack_ovf = WDATA[`TCC_F_OVF];
               s_d.ack_cap = WDATA[`TCC_F_CAP];
            end
            default: s_d.addr = s_d.addr;
         endcase
      end
      if (RD) begin
         case (ADDR)
            `TCC_H_ADDR: s_d.rdata = {4'h0, s_q.addr};
            `TCC_H_DLO: s_d.rdata = s_q.dlo;
            `TCC_H_DHI: s_d.rdata = s_q.dhi;
            `TCC_H_STAT: s_d.rdata = {6'h00, BUS.irq, (s_q.st != tcc_pkg::H_IDLE) || s_q.rd_pend};
            `TCC_H_RLO: s_d.rdata = s_q.rlo;
            `TCC_H_RHI: s_d.rdata = s_q.rhi;
            default: s_d.rdata = `TCC_RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign RDATA = s_q.rdata;
   assign IRQ = BUS.irq;
   assign BUS.addr = s_q.bus_addr;
   assign BUS.wdata = s_q.bus_wdata;
   assign BUS.wr = s_q.bus_wr;
   assign BUS.rd = s_q.bus_rd;
   assign BUS.ack_ovf = s_q.ack_ovf;
   assign BUS.ack_cap = s_q.ack_cap;

endmodule // tcc_host

// *** dv/tcc_chk.sv ***
/* Assertions on the bus joining host end and timer device.
   Assumes the plain signals of one tcc_if and the bench clock and reset. */
`timescale 1ns/1ps
module tcc_chk (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RSTN,
   // register bus
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic irq,
   input wire logic ack_ovf,
   input wire logic ack_cap
);
   // ----------------------------------------
   // shadows of bus writes
   // ----------------------------------------
   // latch is unknown here after any low-byte read
   logic [7:0] lat_q;
   logic [7:0] msk_q;
   logic [7:0] cb_q;
   logic lat_ok_q;
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         lat_q <= 8'h00;
         msk_q <= 8'h00;
         cb_q <= 8'h00;
         lat_ok_q <= 1'b0;
      end else if (wr) begin
         if (addr == 4'h1 || addr == 4'h3) begin
            lat_q <= wdata;
            lat_ok_q <= 1'b1;
         end
         if (addr == 4'h5) cb_q <= wdata;
         if (addr == 4'h7) msk_q <= wdata;
      end else if (rd && (addr == 4'h0 || addr == 4'h2)) begin
         lat_ok_q <= 1'b0;
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);
   a_hi_reads_latch: assert property (rd && (addr == 4'h1 || addr == 4'h3) && lat_ok_q |=> rdata == lat_q)
      else $error("upper byte read missed the latch");
   a_unmapped_zero: assert property (rd && addr > 4'h9 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_ctrl_b_back: assert property (rd && addr == 4'h5 |=> rdata == (cb_q & 8'hDF))
      else $error("control b readback wrong");
   a_irq_masked: assert property (irq |-> (msk_q & 8'h21) != 8'h00)
      else $error("irq without enable");
   a_ack_cap_clears: assert property (ack_cap && msk_q == 8'h20 |=> !irq)
      else $error("capture service left irq");
   a_ack_ovf_clears: assert property (ack_ovf && msk_q == 8'h01 ##1 1'b1 |-> !irq)
      else $error("overflow service left irq");
   a_w1c_clears: assert property (wr && addr == 4'h6 && wdata[5] && msk_q == 8'h20 |=> !irq)
      else $error("writing one kept capture flag");
   a_w0_keeps: assert property (wr && addr == 4'h6 && !wdata[5] && irq && msk_q == 8'h20 |=> $stable(irq))
      else $error("writing zero cleared capture flag");
endmodule // tcc_chk

// *** dv/tb_top.sv ***
/* Bench for the timer block: host end and device end joined by tcc_if.
   Assumes the host command port and a 20 MHz clock. */
`timescale 1ns/1ps
module tb_top;
   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   localparam logic [7:0] w16 = 8'h01;
   localparam logic [7:0] w8 = 8'h04;
   localparam logic [7:0] wlo = 8'h10;
   logic clk, rst_n, wr, rd, cap, cmp, ext, irq, top, bot, dn;
   logic [2:0] addr;
   logic [7:0] wdata, rdata;
   int num_errors = 0;
   int tests_run = 0;
   tcc_if bus ();
   tcc_device u_tcc_device (.SYS_CLK(clk), .RSTN(rst_n), .BUS(bus), .CAPTURE_PIN(cap),
      .COMPARATOR_OUTPUT(cmp), .EXT_TICK_PIN(ext), .TOP_HIT(top), .BOTTOM_HIT(bot), .COUNT_DOWN(dn));
   tcc_host u_tcc_host (.SYS_CLK(clk), .RSTN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .IRQ(irq), .BUS(bus));
   tcc_chk u_tcc_chk (.SYS_CLK(clk), .RSTN(rst_n), .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr),
      .rd(bus.rd), .rdata(bus.rdata), .irq(bus.irq), .ack_ovf(bus.ack_ovf), .ack_cap(bus.ack_cap));
   // ----------------------------------------
   // drivers and compares
   // ----------------------------------------
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      chk({15'h0, g}, {15'h0, e});
   endtask
   task automatic hw(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic hr(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   // commands are refused while busy, so poll before returning
   task automatic go(input logic [7:0] c);
      logic [7:0] s;
      hw(3'h3, c);
      s = 8'h01;
      for (int i = 0; i < 20 && s[0] !== 1'b0; i++) hr(3'h4, s);
   endtask
   task automatic dw(input logic [3:0] a, input logic [15:0] d, input logic [7:0] c);
      hw(3'h0, {4'h0, a});
      hw(3'h1, d[7:0]);
      hw(3'h2, d[15:8]);
      go(c);
   endtask
   task automatic dr(input logic [3:0] a, output logic [15:0] d);
      hw(3'h0, {4'h0, a});
      go(8'h02);
      hr(3'h5, d[7:0]);
      hr(3'h6, d[15:8]);
   endtask
   // source 0 capture pin, 1 comparator, else tick pin
   task automatic drv(input int s, input logic v);
      @(posedge clk);
      if (s == 0) cap <= v;
      else if (s == 1) cmp <= v;
      else ext <= v;
      repeat (8) @(posedge clk);
      #1;
   endtask
   task automatic lat(output int n);
      @(posedge clk);
      cap <= ~cap;
      n = 0;
      while (n < 20 && irq !== 1'b1) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   task automatic final_report();
      if (num_errors == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      logic [15:0] d;
      chk({12'h0, dn, top, bot, irq}, 16'h0002);
      dr(4'h0, d);
      chk(d, 16'h0000);
      dr(4'h5, d);
      chk(d, 16'h0000);
      dr(4'hC, d);
      chk(d, 16'h0000);
   endtask
   task automatic t_latch();
      logic [15:0] d;
      dw(4'h0, 16'h01FF, w16);
      repeat (20) @(posedge clk);
      dr(4'h0, d);
      chk(d, 16'h01FF);
      dw(4'h0, 16'hAB12, w16);
      dw(4'h0, 16'h0034, wlo);
      hw(3'h0, 8'h01);
      go(8'h08);
      hr(3'h5, d[7:0]);
      chk({8'h00, d[7:0]}, 16'h00AB);
      dr(4'h0, d);
      chk(d, 16'hAB34);
   endtask
   task automatic t_modes();
      logic [15:0] e, d;
      logic [3:0] m;
      for (int i = 0; i < 8; i++) begin
         m = 4'(i);
         e = (m[1:0] == 2'h1) ? 16'h00FF : (m[1:0] == 2'h2) ? 16'h01FF : (m[1:0] == 2'h3) ? 16'h03FF : 16'hFFFF;
         dw(4'h4, {14'h0, m[1:0]}, w8);
         dw(4'h5, {11'h0, m[3:2], 3'h0}, w8);
         dw(4'h0, e, w16);
         chk1(top, 1'b1);
         dw(4'h0, e - 16'h0001, w16);
         chk1(top, 1'b0);
      end
      dw(4'h5, 16'h0000, w8);
      dw(4'h4, 16'h0001, w8);
      dw(4'h0, 16'h00FC, w16);
      dw(4'h5, 16'h0001, w8);
      repeat (20) @(posedge clk);
      dw(4'h5, 16'h0000, w8);
      chk1(dn, 1'b1);
      dr(4'h0, d);
      chk1(d < 16'h00FC, 1'b1);
      dw(4'h4, 16'h0000, w8);
   endtask
   task automatic t_count();
      logic [15:0] a, b;
      dw(4'h0, 16'hFFF8, w16);
      dw(4'h7, 16'h0001, w8);
      dw(4'h5, 16'h0001, w8);
      repeat (30) @(posedge clk);
      dw(4'h0, 16'h5000, w16);
      dr(4'h0, a);
      dw(4'h5, 16'h0000, w8);
      chk1(a > 16'h5000 && a < 16'h5040, 1'b1);
      dr(4'h6, a);
      chk(a, 16'h0101);
      dr(4'h0, a);
      repeat (10) @(posedge clk);
      dr(4'h0, b);
      chk(a, b);
      dw(4'h0, 16'h0000, w16);
      dw(4'h5, 16'h0002, w8);
      repeat (80) @(posedge clk);
      dw(4'h5, 16'h0000, w8);
      dr(4'h0, a);
      chk1(a >= 16'h000A && a <= 16'h000D, 1'b1);
      hw(3'h7, 8'h01);
      repeat (2) @(posedge clk);
      chk1(irq, 1'b0);
      dw(4'h0, 16'h0010, w16);
      dw(4'h5, 16'h0007, w8);
      for (int i = 0; i < 3; i++) begin
         drv(2, 1'b1);
         drv(2, 1'b0);
      end
      dw(4'h5, 16'h0000, w8);
      dr(4'h0, a);
      chk(a, 16'h0013);
   endtask
   task automatic t_cap();
      logic [15:0] d;
      dw(4'h5, 16'h0040, w8);
      dw(4'h7, 16'h0020, w8);
      dw(4'h0, 16'h1234, w16);
      drv(0, 1'b1);
      chk1(irq, 1'b1);
      dr(4'h2, d);
      chk(d, 16'h1234);
      dw(4'h0, 16'h2222, w16);
      drv(0, 1'b0);
      dr(4'h2, d);
      chk(d, 16'h1234);
      drv(0, 1'b1);
      dr(4'h2, d);
      chk(d, 16'h2222);
      dw(4'h6, 16'h0000, w8);
      chk1(irq, 1'b1);
      dw(4'h6, 16'h0020, w8);
      chk1(irq, 1'b0);
      dw(4'h5, 16'h0000, w8);
      dw(4'h0, 16'h3333, w16);
      drv(0, 1'b0);
      dr(4'h2, d);
      chk(d, 16'h3333);
      hw(3'h7, 8'h20);
      repeat (2) @(posedge clk);
      chk1(irq, 1'b0);
   endtask
   task automatic t_filter();
      int n0, n1;
      dw(4'h5, 16'h0040, w8);
      lat(n0);
      dw(4'h6, 16'h0020, w8);
      drv(0, 1'b0);
      dw(4'h5, 16'h00C0, w8);
      lat(n1);
      chk(16'(n1 - n0), 16'h0004);
      chk1(n0 < 6, 1'b1);
      dw(4'h6, 16'h0020, w8);
      drv(0, 1'b0);
      @(posedge clk);
      cap <= 1'b1;
      repeat (3) @(posedge clk);
      cap <= 1'b0;
      repeat (12) @(posedge clk);
      chk1(irq, 1'b0);
   endtask
   task automatic t_cmp();
      logic [15:0] d;
      dw(4'h5, 16'h0040, w8);
      dw(4'h8, 16'h0004, w8);
      dw(4'h6, 16'h0020, w8);
      drv(1, 1'b1);
      chk1(irq, 1'b1);
      dr(4'h8, d);
      chk(d & 16'h0024, 16'h0024);
      dw(4'h6, 16'h0020, w8);
      drv(0, 1'b1);
      chk1(irq, 1'b0);
      dw(4'h8, 16'h0000, w8);
      dw(4'h9, 16'h0002, w8);
      dw(4'h6, 16'h0020, w8);
      dw(4'h9, 16'h0003, w8);
      repeat (8) @(posedge clk);
      chk1(irq, 1'b1);
      dw(4'h9, 16'h0000, w8);
   endtask
   task automatic t_top();
      logic [15:0] d;
      dw(4'h2, 16'h0BCD, w16);
      dr(4'h2, d);
      chk(d, 16'h3333);
      dw(4'h5, 16'h0058, w8);
      dw(4'h2, 16'h0040, w16);
      dr(4'h2, d);
      chk(d, 16'h0040);
      dw(4'h0, 16'h0040, w16);
      chk1(top, 1'b1);
      dw(4'h6, 16'h0020, w8);
      drv(0, 1'b0);
      drv(0, 1'b1);
      chk1(irq, 1'b0);
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (40000) @(posedge clk);
      num_errors++;
      final_report();
   end
   initial begin
      rst_n = 1'b0;
      addr = 3'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      cap = 1'b0;
      cmp = 1'b0;
      ext = 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      t_reset();
      t_latch();
      t_modes();
      t_count();
      t_cap();
      t_filter();
      t_cmp();
      t_top();
      final_report();
   end
endmodule // tb_top
